// ===== hdl/quad_dac_pkg.sv
// =====================================================
// shared constants and carriers
package quad_dac_pkg;

  // =====================================================
  // word layout
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int ADDR_BITS = 2;
  localparam int CHAN_COUNT = 4;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 14;
  localparam int DATA_MSB = 11;
  localparam logic [3:0] LAST_BIT = 4'hf;

  // =====================================================
  // clear levels and reset values
  localparam logic [11:0] ZERO_SCALE = 12'h000;
  localparam logic [11:0] MID_SCALE = 12'h800;
  localparam logic IDLE_HIGH = 1'b1;

  // =====================================================
  // buffer shape
  localparam int BUF_SLOTS = 2;

  // =====================================================
  // carriers
  typedef logic [DATA_BITS-1:0] level_t;

  typedef struct packed {
    logic [ADDR_BITS-1:0] chan;
    level_t value;
  } load_word_t;

  typedef struct packed {
    level_t [CHAN_COUNT-1:0] ch;
  } chan_bank_t;

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [WORD_BITS-2:0] shift;
    logic [WORD_BITS-1:0] word;
    logic toggle;
  } link_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } clear_sync_t;

  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic ld_s1;
    logic ld_s2;
    logic ld_prev;
    logic sel_s1;
    logic sel_s2;
    load_word_t [BUF_SLOTS-1:0] slot;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    chan_bank_t chans;
  } core_state_t;

endpackage

// ===== hdl/quad_dac_serial_load.sv
// Functional notes
// - one word is sixteen bits, address first
// - serial input captured on rising serial clock
// - address two top bits, zeros, twelve data
// - load low copies word into addressed channel
// - clear acts asynchronously on channel outputs
// - clear level: zero or mid scale
// - permanent select accepts consecutive words
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_load
  import quad_dac_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_serial_in,
  input wire logic i_load_strobe_n,
  // clear control
  input wire logic i_clear_n,
  input wire logic i_clear_level_select,
  // channel values and status
  output var chan_bank_t o_chan_value,
  output logic [1:0] o_words_pending,
  output logic o_accept_ready,
  output logic o_load_valid
);

  // =====================================================
  // elaboration check
  if (BUF_DEPTH != BUF_SLOTS)
  begin : g_depth_check
    $error("buffer depth must equal the carrier slot count");
  end

  // =====================================================
  // link domain: serial shift register
  link_state_t lnk_r;
  link_state_t lnk_nxt;

  always_comb
  begin
    lnk_nxt = lnk_r;
    if (i_chip_select_n)
    begin
      lnk_nxt.bit_cnt = 4'h0;
    end
    else
    begin
      lnk_nxt.shift = {lnk_r.shift[WORD_BITS-3:0], i_serial_in};
      lnk_nxt.bit_cnt = lnk_r.bit_cnt + 4'h1;
      if (lnk_r.bit_cnt == LAST_BIT)
      begin
        lnk_nxt.word = {lnk_r.shift, i_serial_in};
        lnk_nxt.toggle = ~lnk_r.toggle;
      end
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lnk_r <= '0;
    end
    else
    begin
      lnk_r <= lnk_nxt;
    end
  end

  // =====================================================
  // clear synchroniser, asserted asynchronously
  clear_sync_t clr_r;

  always_ff @(posedge i_clk or negedge i_clear_n)
  begin
    if (!i_clear_n)
    begin
      clr_r <= '0;
    end
    else
    begin
      clr_r.s1 <= 1'b1;
      clr_r.s2 <= clr_r.s1;
    end
  end

  // =====================================================
  // core domain
  core_state_t cs_r;
  core_state_t cs_nxt;
  load_word_t head;
  load_word_t incoming;
  level_t level;
  logic new_word;
  logic in_ready;
  logic out_valid;
  logic load_fall;
  logic push;
  logic pop;

  always_comb
  begin
    cs_nxt = cs_r;
    // synchronisers
    cs_nxt.tog_s1 = lnk_r.toggle;
    cs_nxt.tog_s2 = cs_r.tog_s1;
    cs_nxt.ld_s1 = i_load_strobe_n;
    cs_nxt.ld_s2 = cs_r.ld_s1;
    cs_nxt.ld_prev = cs_r.ld_s2;
    cs_nxt.sel_s1 = i_clear_level_select;
    cs_nxt.sel_s2 = cs_r.sel_s1;
    level = cs_r.sel_s2 ? MID_SCALE : ZERO_SCALE;
    incoming.chan = lnk_r.word[ADDR_MSB:ADDR_LSB];
    incoming.value = lnk_r.word[DATA_MSB:0];
    head = cs_r.slot[cs_r.rd_ptr];
    new_word = cs_r.tog_s2 != cs_r.tog_seen;
    in_ready = cs_r.count != 2'(BUF_DEPTH);
    out_valid = cs_r.count != 2'h0;
    load_fall = cs_r.ld_prev & ~cs_r.ld_s2;
    push = new_word & in_ready;
    pop = load_fall & out_valid & clr_r.s2;
    if (push)
    begin
      cs_nxt.slot[cs_r.wr_ptr] = incoming;
      cs_nxt.wr_ptr = ~cs_r.wr_ptr;
      cs_nxt.tog_seen = cs_r.tog_s2;
    end
    if (pop)
    begin
      cs_nxt.chans.ch[head.chan] = head.value;
      cs_nxt.rd_ptr = ~cs_r.rd_ptr;
    end
    case ({push, pop})
      2'b10:
      begin
        cs_nxt.count = cs_r.count + 2'h1;
      end
      2'b01:
      begin
        cs_nxt.count = cs_r.count - 2'h1;
      end
      default:
      begin
        cs_nxt.count = cs_r.count;
      end
    endcase
    if (!clr_r.s2)
    begin
      cs_nxt.chans.ch = {CHAN_COUNT{level}};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cs_r <= '0;
      cs_r.ld_s1 <= IDLE_HIGH;
      cs_r.ld_s2 <= IDLE_HIGH;
      cs_r.ld_prev <= IDLE_HIGH;
    end
    else
    begin
      cs_r <= cs_nxt;
    end
  end

  // =====================================================
  // outputs
  // clear shows at once on outputs
  assign o_chan_value = clr_r.s2 ? cs_r.chans : chan_bank_t'({CHAN_COUNT{level}});
  assign o_words_pending = cs_r.count;
  assign o_accept_ready = in_ready;
  assign o_load_valid = out_valid;

  // =====================================================
  // checks
  sequence s_load_taken;
    cs_r.ld_prev && !cs_r.ld_s2 && (cs_r.count != 2'h0) && clr_r.s2;
  endsequence

  sequence s_word_taken;
    (cs_r.tog_s2 != cs_r.tog_seen) && (cs_r.count != 2'(BUF_DEPTH)) && !pop;
  endsequence

  property p_load_update;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_load_taken ##1 clr_r.s2 |-> cs_r.chans.ch[$past(head.chan)] == $past(head.value);
  endproperty
  a_load_update: assert property (p_load_update)
    else $error("load did not update addressed channel");

  property p_hold_value;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!pop && clr_r.s2) |=> $stable(cs_r.chans);
  endproperty
  a_hold_value: assert property (p_hold_value)
    else $error("channel value changed without load or clear");

  property p_clear_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!clr_r.s2 && !cs_r.sel_s2) |-> o_chan_value == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear with low select not zero scale");

  property p_clear_mid;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!clr_r.s2 && cs_r.sel_s2) |-> o_chan_value == {CHAN_COUNT{MID_SCALE}};
  endproperty
  a_clear_mid: assert property (p_clear_mid)
    else $error("clear with high select not mid scale");

  property p_clear_async;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_clear_n |-> !clr_r.s2 && !clr_r.s1;
  endproperty
  a_clear_async: assert property (p_clear_async)
    else $error("clear not taken asynchronously");

  property p_clear_override;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(clr_r.s2) |-> cs_r.chans.ch == {CHAN_COUNT{$past(level)}};
  endproperty
  a_clear_override: assert property (p_clear_override)
    else $error("clear release left a channel off the clear level");

  property p_word_push;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_word_taken |=> cs_r.count == $past(cs_r.count) + 2'h1;
  endproperty
  a_word_push: assert property (p_word_push)
    else $error("received word not buffered");

  property p_no_overflow;
    @(posedge i_clk) disable iff (!i_rst_n)
    cs_r.count <= 2'(BUF_DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("buffer count above depth");

  property p_shift_count;
    @(posedge i_sclk) disable iff (!i_rst_n)
    !i_chip_select_n |=> lnk_r.bit_cnt == $past(lnk_r.bit_cnt) + 4'h1;
  endproperty
  a_shift_count: assert property (p_shift_count)
    else $error("selected clock edge did not advance bit count");

  property p_select_restart;
    @(posedge i_sclk) disable iff (!i_rst_n)
    i_chip_select_n |=> lnk_r.bit_cnt == 4'h0 && $stable(lnk_r.shift);
  endproperty
  a_select_restart: assert property (p_select_restart)
    else $error("shift advanced while deselected");

  property p_word_done;
    @(posedge i_sclk) disable iff (!i_rst_n)
    (!i_chip_select_n && lnk_r.bit_cnt == LAST_BIT)
    |=> lnk_r.word == {$past(lnk_r.shift), $past(i_serial_in)} && lnk_r.toggle != $past(lnk_r.toggle);
  endproperty
  a_word_done: assert property (p_word_done)
    else $error("sixteenth bit did not complete the word");

  property p_field_map;
    @(posedge i_clk) disable iff (!i_rst_n)
    push |=> cs_r.slot[$past(cs_r.wr_ptr)].chan == $past(lnk_r.word[ADDR_MSB:ADDR_LSB]);
  endproperty
  a_field_map: assert property (p_field_map)
    else $error("channel address not taken from top bits");

endmodule

`default_nettype wire

// ===== tb/dac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// serial controller driving the link
module dac_host_model
(
  // serial lines
  output var logic o_sclk,
  output var logic o_chip_select_n,
  output var logic o_serial_in,
  output var logic o_load_strobe_n
);
  initial
  begin
    o_sclk = 1'b1;
    o_chip_select_n = 1'b1;
    o_serial_in = 1'b0;
    o_load_strobe_n = 1'b1;
  end

  // =====================================================
  // word shifting
  // sixteen bits selected
  task automatic send(input logic [15:0] w, input logic keep);
    o_chip_select_n = 1'b0;
    #10;
    for (int i = 15; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_serial_in = w[i];
      #16;
      o_sclk = 1'b1;
      #16;
    end
    if (!keep)
      o_chip_select_n = 1'b1;
    o_serial_in = ~o_serial_in;
  endtask

  // =====================================================
  // load pulse
  // raised before next word
  task automatic load();
    o_load_strobe_n = 1'b0;
    #125;
    o_load_strobe_n = 1'b1;
    #125;
  endtask

  // =====================================================
  // cut word
  // partial word, release high, idle clocks
  task automatic abort_word(input logic [15:0] w, input int n);
    o_chip_select_n = 1'b0;
    #10;
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sclk = 1'b0;
      o_serial_in = w[i];
      #16;
      o_sclk = 1'b1;
      #16;
    end
    o_chip_select_n = 1'b1;
    repeat (2)
    begin
      o_sclk = 1'b0;
      #16;
      o_sclk = 1'b1;
      #16;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_quad_dac_serial_load.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
// =====================================================
// bench top
module tb_quad_dac_serial_load;
  import quad_dac_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clear_n = 1'b1;
  logic i_clear_level_select = 1'b0;
  wire logic sclk;
  wire logic cs_n;
  wire logic serial_in;
  wire logic ld_n;
  chan_bank_t o_chan_value;
  chan_bank_t exp;
  logic [1:0] o_words_pending;
  logic o_accept_ready;
  logic o_load_valid;
  logic [11:0] v;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  always #12.5 i_clk = ~i_clk;

  dac_host_model host (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_serial_in(serial_in), .o_load_strobe_n(ld_n));

  quad_dac_serial_load #(.BUF_DEPTH(2)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_chip_select_n(cs_n), .i_serial_in(serial_in), .i_load_strobe_n(ld_n), .i_clear_n(i_clear_n),
    .i_clear_level_select(i_clear_level_select), .o_chan_value(o_chan_value),
    .o_words_pending(o_words_pending), .o_accept_ready(o_accept_ready), .o_load_valid(o_load_valid));

  // =====================================================
  // helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_pend(input logic [1:0] n);
    int k;
    k = 0;
    while (o_words_pending !== n && k < 50)
    begin
      @(negedge i_clk);
      k++;
    end
    `CHK("pending", n, o_words_pending)
  endtask

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // =====================================================
  // tests
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    exp = '0;
    `CHK("bank", exp, o_chan_value)
    `CHK("ready", 1'b1, o_accept_ready)
    for (int c = 0; c < 4; c++)
    begin
      v = 12'ha53 + 12'(c * 273);
      host.send({2'(c), 2'b00, v}, 1'b0);
      wait_pend(2'h1);
      `CHK("valid", 1'b1, o_load_valid)
      host.load();
      exp.ch[c] = v;
      `CHK("bank", exp, o_chan_value)
    end
    host.send({2'h3, 2'h0, 12'h001}, 1'b1);
    host.send({2'h3, 2'h0, 12'hfff}, 1'b0);
    wait_pend(2'h2);
    `CHK("ready", 1'b0, o_accept_ready)
    host.load();
    exp.ch[3] = 12'h001;
    `CHK("oldest", exp, o_chan_value)
    host.load();
    exp.ch[3] = 12'hfff;
    `CHK("newest", exp, o_chan_value)
    `CHK("valid", 1'b0, o_load_valid)
    for (int s = 0; s < 2; s++)
    begin
      @(negedge i_clk);
      i_clear_level_select = s[0];
      repeat (4) @(negedge i_clk);
      i_clear_n = 1'b0;
      exp = {4{(s != 0) ? MID_SCALE : ZERO_SCALE}};
      #2;
      `CHK("clear", exp, o_chan_value)
      @(negedge i_clk);
      i_clear_n = 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK("held", exp, o_chan_value)
    end
    host.send({2'h1, 2'h0, 12'h7e1}, 1'b0);
    wait_pend(2'h1);
    @(negedge i_clk);
    i_clear_n = 1'b0;
    host.load();
    @(negedge i_clk);
    i_clear_n = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHK("clear load", exp, o_chan_value)
    wait_pend(2'h1);
    host.load();
    exp.ch[1] = 12'h7e1;
    `CHK("bank", exp, o_chan_value)
    host.abort_word(16'hffff, 5);
    repeat (4) @(negedge i_clk);
    `CHK("partial", 2'h0, o_words_pending)
    host.send({2'h0, 2'h0, 12'h3c3}, 1'b1);
    wait_pend(2'h1);
    host.load();
    exp.ch[0] = 12'h3c3;
    `CHK("counted", exp, o_chan_value)
    final_report();
  end
endmodule
`default_nettype wire
